// file: src/pic_pins.sv
// Oscillator input select, phase comparator pin and IF counter control
`timescale 1ns/100ps

// How it works
// - Comparator pin drives high when divided oscillator is fast, low when slow.
// - Comparator pin floats when divided and reference frequencies are equal.
// - Comparator pin floats in backup, halt, PLL stop and after reset.
// - FM input reaches divider only when control word one selects it.
// - Reset pin held low long enough resets system and restarts program.
module pic_pins
#(
  parameter int unsigned CNT_W    = pic_pkg::CNT_W,
  parameter int unsigned GATE1_CY = pic_pkg::GATE_1_MS * pic_pkg::CYC_PER_MS,
  parameter int unsigned GATE4_CY = pic_pkg::GATE_4_MS * pic_pkg::CYC_PER_MS,
  parameter int unsigned GATE8_CY = pic_pkg::GATE_8_MS * pic_pkg::CYC_PER_MS,
  parameter int unsigned GATE32_CY = pic_pkg::GATE_32_MS * pic_pkg::CYC_PER_MS,
  parameter int unsigned RST_CY   = pic_pkg::RESET_MIN_CYC
)
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             reset_input_pin_n,
  input  wire pic_pkg::pic_modes_s modes,
  input  wire logic             cw1_wr,
  input  wire logic [3:0]       pll_control_word_one,
  input  wire logic             div_fast,
  input  wire logic             div_slow,
  input  wire logic             fm_osc_input,
  input  wire logic             am_osc_input,
  input  wire logic             if_counter_input,
  input  wire logic             setup_wr,
  input  wire logic [3:0]       counter_setup_instruction,
  input  wire logic             counter_start_instruction,
  input  wire logic             count_end_clr,
  output logic                  divider_in,
  output pic_pkg::pic_osc_e     osc_sel,
  output logic                  phase_comparator_output_o,
  output logic                  phase_comparator_output_oe,
  output logic                  count_end_flag,
  output logic [CNT_W-1:0]      if_count,
  output logic                  sys_reset,
  output logic                  pc_restart
);

  // =====================================================================
  // Reset pin qualification
  // =====================================================================
  localparam int unsigned RCW = $clog2(RST_CY + 1) + 1;

  logic [RCW-1:0] rlow_r;
  logic           sysrst_r;
  logic           restart_r;
  logic           rst_hit;

  assign rst_hit = (rlow_r >= RCW'(RST_CY));

  // Count low cycles; RST_CY low samples in a row reset the system
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rlow_r    <= '0;
      sysrst_r  <= 1'b1;
      restart_r <= 1'b0;
    end
    else
    begin
      if (reset_input_pin_n)
        rlow_r <= '0;
      else if (!rst_hit)
        rlow_r <= rlow_r + RCW'(1);
      sysrst_r  <= rst_hit;
      restart_r <= sysrst_r && !rst_hit;
    end
  end

  assign sys_reset  = sysrst_r;
  assign pc_restart = restart_r;

  // =====================================================================
  // Oscillator input selection
  // =====================================================================
  logic [3:0] cw1_r;
  logic [1:0] band;
  logic       fm_on;
  pic_pkg::pic_osc_e osc_nxt;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cw1_r <= 4'h0;
    else if (sysrst_r)
      cw1_r <= 4'h0;
    else if (cw1_wr)
      cw1_r <= pll_control_word_one;
  end

  assign fm_on = cw1_r[pic_pkg::CW1_FM_SEL];
  assign band  = cw1_r[pic_pkg::CW1_BAND_HI:pic_pkg::CW1_BAND_LO];
  assign osc_nxt = fm_on                    ? pic_pkg::OSC_FM    :
                   (band == pic_pkg::BAND_SW)    ? pic_pkg::OSC_AM_SW :
                   (band == pic_pkg::BAND_MW_LW) ? pic_pkg::OSC_AM_MW :
                   pic_pkg::OSC_NONE;
  assign osc_sel = osc_nxt;

  // Inputs disabled in low-power modes
  assign divider_in = (modes.backup || modes.halt || modes.pll_stop) ? 1'b0 :
                      (osc_nxt == pic_pkg::OSC_FM) ? fm_osc_input :
                      (osc_nxt == pic_pkg::OSC_NONE) ? 1'b0 :
                      am_osc_input;

  // =====================================================================
  // Phase comparator three-state pin
  // =====================================================================
  pic_pkg::pic_tri_s eo_r;
  pic_pkg::pic_tri_s eo_nxt;
  logic              eo_quiet;

  assign eo_quiet = modes.backup || modes.halt || modes.pll_stop ||
                    sysrst_r;
  assign eo_nxt.drive = !eo_quiet && (div_fast ^ div_slow);
  assign eo_nxt.level = div_fast;

  // Registered so the pin never glitches between high and low
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      eo_r <= '0;
    else
      eo_r <= eo_nxt;
  end

  assign phase_comparator_output_o  = eo_r.level && eo_r.drive;
  assign phase_comparator_output_oe = eo_r.drive;

  // =====================================================================
  // IF counter: setup, gate and edge counting
  // =====================================================================
  logic [3:0]      setup_r;
  logic [1:0]      gsel;
  logic            freq_mode;
  logic [CNT_W-1:0] gate_len;
  logic            gate_load;
  logic            gate_done;
  logic            if_d_r;
  logic            if_rise;
  logic            flag_r;
  logic [CNT_W-1:0] cnt_r;
  pic_pkg::pic_cnt_e st_r;
  pic_pkg::pic_cnt_e st_nxt;

  // Gate length lookup for the four gate settings
  function automatic logic [CNT_W-1:0] gate_cycles(input logic [1:0] s);
    unique case (s)
      2'h0: gate_cycles = CNT_W'(GATE1_CY);
      2'h1: gate_cycles = CNT_W'(GATE4_CY);
      2'h2: gate_cycles = CNT_W'(GATE8_CY);
      2'h3: gate_cycles = CNT_W'(GATE32_CY);
    endcase
  endfunction

  assign gsel      = setup_r[pic_pkg::SETUP_GATE_HI:pic_pkg::SETUP_GATE_LO];
  assign freq_mode = setup_r[pic_pkg::SETUP_MODE_HI:pic_pkg::SETUP_MODE_LO]
                     == pic_pkg::MODE_FREQ;
  assign gate_len  = gate_cycles(gsel);
  assign gate_load = (st_r == pic_pkg::CNT_IDLE ||
                      st_r == pic_pkg::CNT_DONE) &&
                     counter_start_instruction && freq_mode &&
                     !sysrst_r;
  assign if_rise   = if_counter_input && !if_d_r;

  // Sequence: idle, armed, gate open, done
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      pic_pkg::CNT_IDLE,
      pic_pkg::CNT_DONE:  if (gate_load) st_nxt = pic_pkg::CNT_ARMED;
      pic_pkg::CNT_ARMED: st_nxt = pic_pkg::CNT_GATE;
      pic_pkg::CNT_GATE:  if (gate_done) st_nxt = pic_pkg::CNT_DONE;
    endcase
    if (sysrst_r)
      st_nxt = pic_pkg::CNT_IDLE;
  end

  pic_gate_timer #(.W(CNT_W)) u_gate
  (
    .clk  (clk),
    .nrst (nrst),
    .load (gate_load),
    .len  (gate_len),
    .done (gate_done)
  );

  // Counter state; flag set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      setup_r <= 4'h0;
      if_d_r  <= 1'b0;
      st_r    <= pic_pkg::CNT_IDLE;
      flag_r  <= 1'b0;
      cnt_r   <= '0;
    end
    else
    begin
      if_d_r <= if_counter_input;
      st_r   <= st_nxt;
      if (sysrst_r)
        setup_r <= 4'h0;
      else if (setup_wr)
        setup_r <= counter_setup_instruction;
      if (gate_load)
        cnt_r <= '0;
      // Armed cycle excluded, so exactly the gate length is counted
      else if (st_r == pic_pkg::CNT_GATE && if_rise)
        cnt_r <= cnt_r + CNT_W'(1);
      if (st_r == pic_pkg::CNT_GATE && gate_done)
        flag_r <= 1'b1;
      else if (count_end_clr || gate_load || sysrst_r)
        flag_r <= 1'b0;
    end
  end

  assign count_end_flag = flag_r;
  assign if_count       = cnt_r;

endmodule

// file: src/pic_pkg.sv
// Package of constants and carrier types for the PLL input and IF counter pins
package pic_pkg;

  // =====================================================================
  // Clock and timing
  // =====================================================================
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned GATE_1_MS     = 1;
  localparam int unsigned GATE_4_MS     = 4;
  localparam int unsigned GATE_8_MS     = 8;
  localparam int unsigned GATE_32_MS    = 32;
  localparam int unsigned CYC_PER_MS    = CLK_MHZ * 1000;
  localparam int unsigned RESET_MIN_CYC = 1;
  localparam int unsigned CNT_W         = 24;

  // =====================================================================
  // Control word and setup field positions
  // =====================================================================
  localparam int unsigned CW1_BAND_LO  = 0;
  localparam int unsigned CW1_BAND_HI  = 1;
  localparam int unsigned CW1_FM_SEL   = 2;
  localparam int unsigned SETUP_GATE_LO = 0;
  localparam int unsigned SETUP_GATE_HI = 1;
  localparam int unsigned SETUP_MODE_LO = 2;
  localparam int unsigned SETUP_MODE_HI = 3;

  localparam logic [1:0] BAND_SW    = 2'h2;
  localparam logic [1:0] BAND_MW_LW = 2'h3;
  localparam logic [1:0] MODE_FREQ  = 2'h0;

  // =====================================================================
  // Types
  // =====================================================================
  typedef enum logic [1:0]
  {
    OSC_NONE  = 2'h0,
    OSC_FM    = 2'h1,
    OSC_AM_SW = 2'h2,
    OSC_AM_MW = 2'h3
  } pic_osc_e;

  typedef enum logic [1:0]
  {
    CNT_IDLE  = 2'h0,
    CNT_ARMED = 2'h1,
    CNT_GATE  = 2'h2,
    CNT_DONE  = 2'h3
  } pic_cnt_e;

  typedef struct packed
  {
    logic backup;
    logic halt;
    logic pll_stop;
  } pic_modes_s;

  typedef struct packed
  {
    logic drive;
    logic level;
  } pic_tri_s;

endpackage

// file: src/pic_gate_timer.sv
// Gate time counter for the IF frequency measurement
`timescale 1ns/100ps

module pic_gate_timer
#(
  parameter int unsigned W = pic_pkg::CNT_W
)
(
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] len,
  output logic              done
);

  logic [W-1:0] cnt_r;
  logic         run_r;
  logic         done_r;

  // =====================================================================
  // Down counter, done pulses on the last cycle of the gate
  // =====================================================================
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r  <= '0;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= run_r && (cnt_r == W'(1));
      if (load)
      begin
        cnt_r <= len;
        run_r <= 1'b1;
      end
      else if (run_r)
      begin
        cnt_r <= cnt_r - W'(1);
        run_r <= (cnt_r != W'(1));
      end
    end
  end

  assign done = done_r;

endmodule

// file: test/pic_far_model.sv
// Model of the VCO, IF stage and loop divider outside the pins
`timescale 1ns/100ps
module pic_far_model
(
  input  wire logic       clk,
  input  wire logic [1:0] rel,
  output logic            div_fast,
  output logic            div_slow,
  output logic            fm_osc_input,
  output logic            am_osc_input,
  output logic            if_counter_input
);
  logic [3:0] ph_r = 4'h0;

  // Oscillators run free; moved off the rising edge to avoid races
  always @(negedge clk) ph_r <= ph_r + 4'h1;
  assign fm_osc_input     = ph_r[0];
  assign am_osc_input     = ph_r[2];
  assign if_counter_input = ph_r[1];

  // Divider compare: 1 fast, 2 slow, else locked
  assign div_fast = (rel == 2'h1);
  assign div_slow = (rel == 2'h2);
endmodule

// file: test/pic_pins_asserts.sv
// Checker for the PLL pin and IF counter block
`timescale 1ns/100ps
module pic_pins_asserts
#(
  parameter int unsigned GATE1_CY  = 10,
  parameter int unsigned GATE4_CY  = 40,
  parameter int unsigned GATE8_CY  = 80,
  parameter int unsigned GATE32_CY = 320
)
(
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic                reset_input_pin_n,
  input wire pic_pkg::pic_modes_s modes,
  input wire logic                cw1_wr,
  input wire logic [3:0]          pll_control_word_one,
  input wire logic                div_fast,
  input wire logic                div_slow,
  input wire logic                fm_osc_input,
  input wire logic                setup_wr,
  input wire logic [3:0]          counter_setup_instruction,
  input wire logic                counter_start_instruction,
  input wire logic                divider_in,
  input wire pic_pkg::pic_osc_e   osc_sel,
  input wire logic                phase_comparator_output_o,
  input wire logic                phase_comparator_output_oe,
  input wire logic                count_end_flag,
  input wire logic                sys_reset,
  input wire logic                pc_restart
);
  logic [15:0] since_r;
  logic [1:0]  gate_r;
  wire  [15:0] gate_len;
  wire         oe = phase_comparator_output_oe;
  wire         eo = phase_comparator_output_o;
  wire         quiet = sys_reset || (modes != 3'h0);
  wire         live = reset_input_pin_n && !quiet;
  wire         run = reset_input_pin_n && !sys_reset;

  // Cycles since the last start and gate of the last setup
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) since_r <= 16'h0;
    else since_r <= counter_start_instruction ? 16'h0 : since_r + 16'h1;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) gate_r <= 2'h0;
    else if (setup_wr) gate_r <= counter_setup_instruction[1:0];
  assign gate_len = (gate_r == 2'h0) ? 16'(GATE1_CY) :
                    (gate_r == 2'h1) ? 16'(GATE4_CY) :
                    (gate_r == 2'h2) ? 16'(GATE8_CY) : 16'(GATE32_CY);

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Steps of a control word load and of a reset pin release
  sequence s_fm_load;
    cw1_wr && run && pll_control_word_one[2];
  endsequence
  sequence s_release;
    !reset_input_pin_n ##1 reset_input_pin_n;
  endsequence

  property p_eo_fast;
    live && div_fast && !div_slow |=> oe && eo;
  endproperty
  property p_eo_slow;
    live && div_slow && !div_fast |=> oe && !eo;
  endproperty
  property p_eo_match;
    live && (div_fast == div_slow) |=> !oe;
  endproperty
  property p_eo_quiet;
    quiet |=> !oe;
  endproperty
  property p_fm_sel;
    s_fm_load |=> osc_sel == pic_pkg::OSC_FM
      && (modes != 3'h0 || sys_reset || divider_in == fm_osc_input);
  endproperty
  property p_band;
    cw1_wr && run && pll_control_word_one[2:1] == 2'h1 |=> osc_sel ==
      ($past(pll_control_word_one[0]) ? pic_pkg::OSC_AM_MW
                                      : pic_pkg::OSC_AM_SW);
  endproperty
  property p_gate_time;
    $rose(count_end_flag) |-> since_r == gate_len + 16'h1;
  endproperty
  // Low sample counted first, then the system reset level follows
  property p_pin_reset;
    !reset_input_pin_n |-> ##2 sys_reset;
  endproperty
  property p_restart;
    s_release |=> ##1 pc_restart && !sys_reset ##1 !pc_restart;
  endproperty

  a_eo_fast: assert property (p_eo_fast)
    else $error("comparator not high while fast");
  a_eo_slow: assert property (p_eo_slow)
    else $error("comparator not low while slow");
  a_eo_match: assert property (p_eo_match)
    else $error("comparator driven while locked");
  a_eo_quiet: assert property (p_eo_quiet)
    else $error("comparator driven in low power or reset");
  a_fm_sel: assert property (p_fm_sel)
    else $error("FM input not routed");
  a_band: assert property (p_band)
    else $error("AM band select wrong");
  a_gate_time: assert property (p_gate_time)
    else $error("count end at wrong cycle");
  a_pin_reset: assert property (p_pin_reset)
    else $error("reset pin ignored");
  a_restart: assert property (p_restart)
    else $error("no restart pulse");
endmodule

bind pic_pins pic_pins_asserts #(.GATE1_CY(GATE1_CY), .GATE4_CY(GATE4_CY),
  .GATE8_CY(GATE8_CY), .GATE32_CY(GATE32_CY)) pic_pins_asserts_i (.clk,
  .nrst, .reset_input_pin_n, .modes, .cw1_wr, .pll_control_word_one,
  .div_fast, .div_slow, .fm_osc_input, .setup_wr, .counter_setup_instruction,
  .counter_start_instruction, .divider_in, .osc_sel,
  .phase_comparator_output_o, .phase_comparator_output_oe, .count_end_flag,
  .sys_reset, .pc_restart);

// file: test/testbench.sv
// Self-checking bench for the PLL pin and IF counter block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
  num_errors++; $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
  end end
module testbench;
  localparam int GL [4] = '{10, 40, 80, 320};
  localparam logic [3:0] CW [4] = '{4'h4, 4'h2, 4'h3, 4'h0};
  localparam pic_pkg::pic_osc_e OS [4] = '{pic_pkg::OSC_FM,
    pic_pkg::OSC_AM_SW, pic_pkg::OSC_AM_MW, pic_pkg::OSC_NONE};
  logic clk = 1'b0, nrst = 1'b0, reset_input_pin_n = 1'b1, cw1_wr = 1'b0;
  logic setup_wr = 1'b0, counter_start_instruction = 1'b0;
  logic count_end_clr = 1'b0;
  logic [3:0] pll_control_word_one = 4'h0, counter_setup_instruction = 4'h0;
  logic [1:0] rel = 2'h0;
  pic_pkg::pic_modes_s modes = 3'h0;
  logic div_fast, div_slow, fm_osc_input, am_osc_input, if_counter_input;
  logic divider_in, phase_comparator_output_o, phase_comparator_output_oe;
  logic count_end_flag, sys_reset, pc_restart, exp_div, in_rng;
  logic [pic_pkg::CNT_W-1:0] if_count;
  pic_pkg::pic_osc_e osc_sel;
  int num_errors = 0, tests_run = 0, n;

  always #2.5 clk = ~clk;

  pic_pins #(.GATE1_CY(GL[0]), .GATE4_CY(GL[1]), .GATE8_CY(GL[2]),
    .GATE32_CY(GL[3]), .RST_CY(1)) pic_pins_i (.clk, .nrst,
    .reset_input_pin_n, .modes, .cw1_wr, .pll_control_word_one, .div_fast,
    .div_slow, .fm_osc_input, .am_osc_input, .if_counter_input, .setup_wr,
    .counter_setup_instruction, .counter_start_instruction, .count_end_clr,
    .divider_in, .osc_sel, .phase_comparator_output_o,
    .phase_comparator_output_oe, .count_end_flag, .if_count, .sys_reset,
    .pc_restart);
  pic_far_model pic_far_model_i (.clk, .rel, .div_fast, .div_slow,
    .fm_osc_input, .am_osc_input, .if_counter_input);

  // Program side writes: data set up with its one-cycle strobe
  task automatic wr_cw1(input logic [3:0] v);
    @(negedge clk) {pll_control_word_one, cw1_wr} = {v, 1'b1};
    @(negedge clk) cw1_wr = 1'b0;
  endtask
  task automatic wr_setup(input logic [3:0] v);
    @(negedge clk) {counter_setup_instruction, setup_wr} = {v, 1'b1};
    @(negedge clk) setup_wr = 1'b0;
  endtask
  task automatic go(input logic clear);
    @(negedge clk) {counter_start_instruction, count_end_clr} = {~clear, clear};
    @(negedge clk) {counter_start_instruction, count_end_clr} = 2'h0;
  endtask

  task automatic end_sim;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests take
  initial
  begin
    #50000;
    num_errors++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    `CHK("oe_reset", 1'b0, phase_comparator_output_oe)
    for (int r = 0; r < 3; r++)
    begin
      @(negedge clk) rel = r[1:0];
      @(negedge clk);
      `CHK("oe", r != 0, phase_comparator_output_oe)
      if (r != 0) `CHK("eo", r == 1, phase_comparator_output_o)
    end
    rel = 2'h1;
    for (int b = 0; b < 3; b++)
    begin
      @(negedge clk) modes = pic_pkg::pic_modes_s'(3'h1 << b);
      @(negedge clk);
      `CHK("oe_low_power", 1'b0, phase_comparator_output_oe)
    end
    modes = 3'h0;
    for (int k = 0; k < 4; k++)
    begin
      wr_cw1(CW[k]);
      exp_div = k == 0 ? fm_osc_input : k == 3 ? 1'b0 : am_osc_input;
      `CHK("osc_sel", OS[k], osc_sel)
      `CHK("div_in", exp_div, divider_in)
    end
    for (int g = 0; g < 4; g++)
    begin
      wr_setup({2'h0, g[1:0]});
      go(1'b0);
      n = 0;
      while (count_end_flag !== 1'b1 && n < 400)
      begin
        @(negedge clk);
        n++;
      end
      `CHK("gate_cycles", GL[g] + 1, n)
      in_rng = if_count >= GL[g] / 4 && if_count <= GL[g] / 4 + 2;
      `CHK("if_count", 1'b1, in_rng)
      repeat (3) @(negedge clk);
      `CHK("flag_holds", 1'b1, count_end_flag)
      go(1'b1);
      `CHK("flag_clear", 1'b0, count_end_flag)
    end
    wr_setup(4'h4);
    go(1'b0);
    repeat (GL[0] + 10) @(negedge clk);
    `CHK("flag_refused", 1'b0, count_end_flag)
    // Low sample counted first, so reset level shows one edge later
    @(negedge clk) reset_input_pin_n = 1'b0;
    @(negedge clk) reset_input_pin_n = 1'b1;
    @(negedge clk);
    `CHK("sys_reset", 1'b1, sys_reset)
    @(negedge clk);
    `CHK("pc_restart", 1'b1, pc_restart)
    `CHK("oe_pin_reset", 1'b0, phase_comparator_output_oe)
    repeat (3) @(negedge clk);
    end_sim();
  end
endmodule
